/* File: ext_cfg_pkg.sv */
// package for the extended configuration load block
// assumes a single 40 MHz device clock and pins sampled on its rising edge
package ext_cfg_pkg;
  // ------------------------------------------------------------
  // widths and field positions
  // ------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int DLL_BIT = 0;
  localparam int DRIVE_BIT = 1;
  localparam int BANK_LO_BIT = 0;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int LOAD_CYCLES = 2;
  localparam logic [1:0] BUSY_LOAD = 2'h2;
  // ------------------------------------------------------------
  // wishbone register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [31:0] RST_CTRL = 32'h00000001;
  localparam logic [15:0] RST_COUNT = 16'h0000;
endpackage : ext_cfg_pkg

/* File: ext_cfg_decode.sv */
// command decoder for the extended configuration load
// assumes command pins are already synchronous to the device clock
`timescale 1ns/1ps
module ext_cfg_decode (
  input wire logic cs_n, // chip select, active low
  input wire logic row_n, // row strobe, active low
  input wire logic col_n, // column strobe, active low
  input wire logic wr_n, // write strobe, active low
  input wire logic clock_gate, // clock gate input level
  input wire logic bank_sel_lo, // low bank-select bit
  output logic load_hit // decoded load command
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // all strobes low plus bank_sel_lo and clock_gate high
  always_comb begin
    load_hit = ~cs_n & ~row_n & ~col_n & ~wr_n & bank_sel_lo & clock_gate;
  end
endmodule : ext_cfg_decode

/* File: ext_cfg_load.sv */
// extended configuration register load path of a ddr memory device
// assumes the controller precharges all banks before loading
`timescale 1ns/1ps
module ext_cfg_load #(
  parameter int ADDR_W = ext_cfg_pkg::ADDR_W,
  parameter int BANK_W = ext_cfg_pkg::BANK_W
) (
  input wire logic SYS_CLK, // 40 MHz device clock
  input wire logic RST_N, // async reset, active low
  input wire logic CLK_EN, // clock enable, freezes state when low
  input wire logic CS_N, // chip select, active low
  input wire logic ROW_N, // row strobe, active low
  input wire logic COL_N, // column strobe, active low
  input wire logic WR_N, // write strobe, active low
  input wire logic CLOCK_GATE_IN, // clock gate level
  input wire logic [ADDR_W-1:0] ADDR, // address pins
  input wire logic [BANK_W-1:0] BANK_SEL, // bank-select pins
  output logic DLL_ENABLE, // delay-lock loop enabled
  output logic WEAK_DRIVE, // weak output drive selected
  output logic CFG_BUSY, // load still completing
  output logic CFG_VALID, // register loaded at least once
  input wire logic [31:0] WB_ADR_I, // wishbone address
  input wire logic [31:0] WB_DAT_I, // wishbone write data
  output logic [31:0] WB_DAT_O, // wishbone read data
  input wire logic WB_WE_I, // wishbone write enable
  input wire logic [3:0] WB_SEL_I, // wishbone byte selects
  input wire logic WB_CYC_I, // wishbone cycle
  input wire logic WB_STB_I, // wishbone strobe
  output logic WB_ACK_O, // wishbone acknowledge
  output logic WB_ERR_O // wishbone error for unmapped address
);
  localparam int CFG_W = ADDR_W + BANK_W;

  // ------------------------------------------------------------
  // state and signals
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } load_state_type;

  load_state_type state_reg, state_next;
  logic [CFG_W-1:0] cfg_reg, cfg_next;
  logic valid_reg, valid_next;
  logic [1:0] busy_cnt_reg, busy_cnt_next;
  logic [15:0] load_cnt_reg, load_cnt_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  logic [31:0] rdata_reg, rdata_next;
  logic load_hit;
  logic cmd_take;
  logic wb_req;
  logic [7:0] wb_ofs;

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  ext_cfg_decode u_decode (
    .cs_n(CS_N),
    .row_n(ROW_N),
    .col_n(COL_N),
    .wr_n(WR_N),
    .clock_gate(CLOCK_GATE_IN),
    .bank_sel_lo(BANK_SEL[ext_cfg_pkg::BANK_LO_BIT]),
    .load_hit(load_hit)
  );

  // software can mask the pin command through ctrl bit 0
  assign cmd_take = load_hit & ctrl_reg[0];

  // merges a byte-enabled write into an old word
  function automatic logic [31:0] byte_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction : byte_merge

  // ------------------------------------------------------------
  // load path next state
  // ------------------------------------------------------------
  // a reload during busy restarts the two-cycle window with new data
  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_reg;
    valid_next = valid_reg;
    busy_cnt_next = busy_cnt_reg;
    load_cnt_next = load_cnt_reg;
    unique case (state_reg)
      ST_IDLE: begin
      end
      ST_BUSY: begin
        if (busy_cnt_reg == 2'h1) begin
          state_next = ST_IDLE;
          busy_cnt_next = 2'h0;
        end else begin
          busy_cnt_next = busy_cnt_reg - 2'h1;
        end
      end
    endcase
    if (cmd_take) begin
      cfg_next = {BANK_SEL, ADDR};
      valid_next = 1'b1;
      state_next = ST_BUSY;
      busy_cnt_next = ext_cfg_pkg::BUSY_LOAD;
      load_cnt_next = load_cnt_reg + 16'h0001;
    end
  end

  // registers of the load path; the config word itself has no reset value
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
      valid_reg <= 1'b0;
      busy_cnt_reg <= 2'h0;
      load_cnt_reg <= ext_cfg_pkg::RST_COUNT;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      valid_reg <= valid_next;
      busy_cnt_reg <= busy_cnt_next;
      load_cnt_reg <= load_cnt_next;
    end
  end

  // config word left unreset on purpose: its content is undefined until loaded
  always_ff @(posedge SYS_CLK) begin
    if (CLK_EN) begin
      cfg_reg <= cfg_next;
    end
  end

  // ------------------------------------------------------------
  // decoded outputs
  // ------------------------------------------------------------
  // DLL_ENABLE and WEAK_DRIVE gated by valid so an unloaded register drives known zeros
  always_comb begin
    DLL_ENABLE = valid_reg & ~cfg_reg[ext_cfg_pkg::DLL_BIT];
    WEAK_DRIVE = valid_reg & cfg_reg[ext_cfg_pkg::DRIVE_BIT];
    CFG_BUSY = (state_reg == ST_BUSY);
    CFG_VALID = valid_reg;
  end

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_reg & ~err_reg;
  assign wb_ofs = WB_ADR_I[7:0];

  // one wait state: answer in the cycle after the request is seen
  always_comb begin
    ack_next = 1'b0;
    err_next = 1'b0;
    rdata_next = rdata_reg;
    ctrl_next = ctrl_reg;
    if (wb_req) begin
      ack_next = 1'b1;
      rdata_next = 32'h00000000;
      unique case (wb_ofs)
        ext_cfg_pkg::OFS_CONFIG: begin
          rdata_next[CFG_W-1:0] = valid_reg ? cfg_reg : '0;
        end
        ext_cfg_pkg::OFS_STATUS: begin
          rdata_next[1:0] = {CFG_BUSY, valid_reg};
        end
        ext_cfg_pkg::OFS_COUNT: begin
          rdata_next[15:0] = load_cnt_reg;
        end
        ext_cfg_pkg::OFS_CTRL: begin
          rdata_next = ctrl_reg;
          if (WB_WE_I) begin
            ctrl_next = byte_merge(ctrl_reg, WB_DAT_I, WB_SEL_I) & 32'h00000001;
          end
        end
        default: begin
          ack_next = 1'b0;
          err_next = 1'b1;
        end
      endcase
      if (WB_WE_I) begin
        rdata_next = 32'h00000000;
      end
    end
  end

  // bus registers
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      ctrl_reg <= ext_cfg_pkg::RST_CTRL;
    end else if (CLK_EN) begin
      ack_reg <= ack_next;
      err_reg <= err_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_ERR_O = err_reg;
  assign WB_DAT_O = rdata_reg;
endmodule : ext_cfg_load

/* File: ext_cfg_load_properties.sv */
// assertions on the ports of the extended configuration load block
// assumes one clock and a bench that holds the clock enable high
`timescale 1ns/1ps
module ext_cfg_load_properties #(
  parameter int ADDR_W = 13,
  parameter int BANK_W = 2
) (
  input wire logic SYS_CLK, // clock
  input wire logic RST_N, // reset
  input wire logic CS_N, // select
  input wire logic ROW_N, // row
  input wire logic COL_N, // column
  input wire logic WR_N, // write
  input wire logic CLOCK_GATE_IN, // gate
  input wire logic [ADDR_W-1:0] ADDR, // address
  input wire logic [BANK_W-1:0] BANK_SEL, // bank
  input wire logic DLL_ENABLE, // loop on
  input wire logic WEAK_DRIVE, // weak
  input wire logic CFG_BUSY, // busy
  input wire logic CFG_VALID, // valid
  input wire logic WB_ACK_O, // ack
  input wire logic WB_ERR_O // error
);
  // ----------------------------------------
  // pin command; the enable bit is hidden, so only one direction holds
  // ----------------------------------------
  wire cmd = !CS_N && !ROW_N && !COL_N && !WR_N && BANK_SEL[0] && CLOCK_GATE_IN;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence busy_two; CFG_BUSY[*2]; endsequence
  sequence busy_over; !CFG_BUSY || $past(cmd) || $past(cmd, 2); endsequence
  a_busy_cause: assert property ($rose(CFG_BUSY) |-> $past(cmd))
    else $error("busy without load");
  a_busy_len: assert property ($rose(CFG_BUSY) |-> busy_two ##1 busy_over)
    else $error("busy length wrong");
  a_drive_cap: assert property ($rose(CFG_BUSY) |-> WEAK_DRIVE == $past(ADDR[1]))
    else $error("drive not captured");
  a_dll_cap: assert property ($rose(CFG_BUSY) |-> DLL_ENABLE == !$past(ADDR[0]))
    else $error("loop bit not captured");
  a_cfg_hold: assert property (!$past(cmd) |-> $stable(WEAK_DRIVE) && $stable(DLL_ENABLE))
    else $error("config changed");
  a_valid_keep: assert property (CFG_VALID |=> CFG_VALID)
    else $error("valid lost");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  a_ack_excl: assert property (!(WB_ACK_O && WB_ERR_O))
    else $error("ack with error");
endmodule : ext_cfg_load_properties

bind ext_cfg_load ext_cfg_load_properties #(.ADDR_W(ADDR_W), .BANK_W(BANK_W))
  ext_cfg_load_properties_inst (.SYS_CLK, .RST_N, .CS_N, .ROW_N, .COL_N, .WR_N,
  .CLOCK_GATE_IN, .ADDR, .BANK_SEL, .DLL_ENABLE, .WEAK_DRIVE, .CFG_BUSY, .CFG_VALID,
  .WB_ACK_O, .WB_ERR_O);

/* File: ddr_ctrl_model.sv */
// controller-side model driving the load command pins
// assumes go is pulsed for one cycle per command
`timescale 1ns/1ps
module ddr_ctrl_model (
  input wire logic clk, // device clock
  input wire logic go, // issue a load next cycle
  input wire logic [1:0] mode, // drive and loop bits
  input wire logic ba_lo, // low bank-select level
  output logic [3:0] cmd_n = 4'hf, // select, row, column, write
  output logic [12:0] addr = 13'h0, // address pins
  output logic [1:0] ba = 2'h0 // bank-select pins
);
  // ----------------------------------------
  // one command cycle, then deselect
  // ----------------------------------------
  always @(posedge clk) begin
    if (go) begin
      cmd_n <= 4'h0;
      addr <= {11'h0, mode}; // unused bits zero
      ba <= {1'b0, ba_lo};
    end else begin
      cmd_n <= 4'hf;
      addr <= ~addr; // no pull here, so toggle rather than hold the last value
      ba <= ~ba;
    end
  end
endmodule : ddr_ctrl_model

/* File: ext_cfg_load_tb.sv */
// self-checking bench for the extended configuration load block
// assumes the controller model drives the pins and the bench the bus
`timescale 1ns/1ps
module ext_cfg_load_tb;
  logic SYS_CLK = 0, RST_N = 0, CLK_EN = 1, CLOCK_GATE_IN = 1, WB_WE_I = 0;
  logic WB_CYC_I = 0, WB_STB_I = 0, go = 0, lo = 1, x_dll = 0, x_weak = 0, got_err;
  logic [1:0] mode = 2'h0;
  logic [3:0] WB_SEL_I = 4'hf;
  logic [31:0] WB_ADR_I = 32'h0, WB_DAT_I = 32'h0, rdat, x_cfg;
  wire [3:0] cmd_n;
  wire [12:0] ADDR;
  wire [1:0] BANK_SEL;
  wire CS_N = cmd_n[3], ROW_N = cmd_n[2], COL_N = cmd_n[1], WR_N = cmd_n[0];
  wire [31:0] WB_DAT_O;
  wire DLL_ENABLE, WEAK_DRIVE, CFG_BUSY, CFG_VALID, WB_ACK_O, WB_ERR_O;
  int errors = 0, n_tests = 0, loads = 0;
  always #12.5 SYS_CLK = ~SYS_CLK;
  ext_cfg_load ext_cfg_load_inst (.SYS_CLK, .RST_N, .CLK_EN, .CS_N, .ROW_N, .COL_N, .WR_N,
    .CLOCK_GATE_IN, .ADDR, .BANK_SEL, .DLL_ENABLE, .WEAK_DRIVE, .CFG_BUSY, .CFG_VALID,
    .WB_ADR_I, .WB_DAT_I, .WB_DAT_O, .WB_WE_I, .WB_SEL_I, .WB_CYC_I, .WB_STB_I,
    .WB_ACK_O, .WB_ERR_O);
  ddr_ctrl_model ddr_ctrl_model_inst (.clk(SYS_CLK), .go, .mode, .ba_lo(lo), .cmd_n,
    .addr(ADDR), .ba(BANK_SEL));
  // ----------------------------------------
  // shared compare and bus cycle
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge SYS_CLK);
    WB_CYC_I <= 1;
    WB_STB_I <= 1;
    WB_WE_I <= w;
    WB_ADR_I <= {24'h0, a};
    WB_DAT_I <= d;
    do @(posedge SYS_CLK); while (WB_ACK_O !== 1'b1 && WB_ERR_O !== 1'b1);
    rdat = WB_DAT_O;
    got_err = WB_ERR_O;
    WB_CYC_I <= 0;
    WB_STB_I <= 0;
  endtask : wb
  // one pin command, loads spaced so busy always ends first
  task automatic load(input logic [1:0] m, input logic b, input logic hit);
    @(posedge SYS_CLK);
    go <= 1;
    mode <= m;
    lo <= b;
    @(posedge SYS_CLK);
    go <= 0;
    if (hit) begin
      x_dll = !m[0];
      x_weak = m[1];
      x_cfg = {17'h0, 2'b01, 11'h0, m};
      loads++;
    end
    @(posedge SYS_CLK); #1;
    chk("busy", CFG_BUSY, hit);
    chk("dll", DLL_ENABLE, x_dll);
    chk("weak", WEAK_DRIVE, x_weak);
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk("busy end", CFG_BUSY, 0);
  endtask : load
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("valid", CFG_VALID, 0);
    wb(ext_cfg_pkg::OFS_CTRL, 0, 0);
    chk("ctrl", rdat, ext_cfg_pkg::RST_CTRL);
    $display("reset test done");
  endtask : t_reset
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      load(2'(i), 1, 1);
      wb(ext_cfg_pkg::OFS_CONFIG, 0, 0);
      chk("config", rdat, x_cfg);
    end
    wb(ext_cfg_pkg::OFS_STATUS, 1, 32'hffffffff);
    wb(ext_cfg_pkg::OFS_STATUS, 0, 0);
    chk("status", rdat, 32'h1);
    $display("mode test done");
  endtask : t_modes
  task automatic t_refuse;
    load(2'h1, 0, 0);
    @(posedge SYS_CLK) CLOCK_GATE_IN <= 0;
    load(2'h2, 1, 0);
    @(posedge SYS_CLK) CLOCK_GATE_IN <= 1; // high again before a real load
    wb(ext_cfg_pkg::OFS_CTRL, 1, 0);
    load(2'h2, 1, 0);
    wb(ext_cfg_pkg::OFS_CTRL, 1, 1);
    load(2'h2, 1, 1);
    wb(8'h10, 0, 0);
    chk("unmapped", got_err, 1);
    wb(ext_cfg_pkg::OFS_COUNT, 0, 0);
    chk("count", rdat, loads);
    $display("refusal test done");
  endtask : t_refuse
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (6) @(posedge SYS_CLK);
    RST_N <= 1;
    t_reset();
    t_modes();
    t_refuse();
    give_verdict();
  end
  // watchdog, far beyond the fewer than one hundred cycles needed
  initial begin
    repeat (4000) @(posedge SYS_CLK);
    errors++;
    give_verdict();
  end
endmodule : ext_cfg_load_tb
